//--- hw/bcc_pkg.sv
// package of constants and types for the bridge current chopper
package bcc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OFF_TIME_PIN = 8'h04;
    localparam logic [7:0] ADDR_REF_A = 8'h08;
    localparam logic [7:0] ADDR_REF_B = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;
    // ctrl fields
    localparam int CTRL_EN_A = 0;
    localparam int CTRL_EN_B = 1;
    localparam int CTRL_DIR_A = 2;
    localparam int CTRL_DIR_B = 3;
    // reference fields: bit 8 sign (1 = negative), bits 7:0 magnitude
    localparam int REF_W = 8;
    localparam int REF_SIGN = 8;
    // status bits
    localparam int ST_TRIP_A = 0;
    localparam int ST_TRIP_B = 1;
    localparam int ST_OCP = 2;
    localparam int ST_THERM = 3;
    localparam int ST_W = 4;
    // off time
    localparam int CLK_MHZ = 40;
    localparam int OFF_TIME_PIN_MIN_US = 10;
    localparam int OFF_TIME_PIN_MAX_US = 150;
    localparam int OFF_TIME_PIN_MIN_CYC = OFF_TIME_PIN_MIN_US * CLK_MHZ;
    localparam int OFF_TIME_PIN_MAX_CYC = OFF_TIME_PIN_MAX_US * CLK_MHZ;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] OFF_TIME_PIN_RST = 13'h05c8;
    localparam int SLOW_NUM = 5;
    localparam int SLOW_SHIFT = 3;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PH_ON = 2'b00,
        PH_SLOW = 2'b01,
        PH_FAST = 2'b10
    } bcc_phase_e;
endpackage

//--- hw/bcc_chopper.sv
// two-bridge fixed off-time current chopper with protection and apb registers
// Contract
// - two independent choppers, one per full bridge
// - each compares its sensed voltage to its own target reference
// - sense above reference trips, starts off counter and decay
// - decay opens with slow decay, both low sides on
// - after five eighths of off time switch to fast decay
// - programmed off time covers slow plus fast decay
// - off time spans about 10 us to 150 us
// - zero current keeps all four switches off in every phase
// - forward: on hs1+ls2, slow both ls, fast ls1 only
// - reverse: on ls1+hs2, slow both ls, fast ls2 only
// - overcurrent or short disables stage, pulls fault line low
// - protection covers every output: ground, supply, output shorts, overload
// - after overcurrent hold disabled until fault line below release
// - thermal shutdown disables stage and pulls fault line low
// - thermal release only below shutdown temperature minus hysteresis
// - positive reference sign means current terminal 1 to 2
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module bcc_chopper (
    input wire logic pclk, // apb clock, 40 mhz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [1:0] sense_above_ref, // comparator outputs, per bridge
    input wire logic [1:0] overcurrent, // ocp/short detectors, per bridge
    input wire logic shutdown_temperature, // above shutdown point
    input wire logic temp_safe, // below shutdown minus hysteresis
    input wire logic fault_line_in, // en/fault pin level
    input wire logic fault_below_release, // en/fault under release level
    output logic fault_line_out, // en/fault pin drive value
    output logic fault_line_oe, // en/fault pull-down enable
    output logic [bcc_pkg::REF_W-1:0] target_reference_a, // dac code bridge a
    output logic [bcc_pkg::REF_W-1:0] target_reference_b, // dac code bridge b
    output logic [1:0] high_switch_term1, // per bridge
    output logic [1:0] low_switch_term1, // per bridge
    output logic [1:0] high_switch_term2, // per bridge
    output logic [1:0] low_switch_term2, // per bridge
    output logic irq // level interrupt
);
    // input synchronisers
    logic [1:0] cmp_s1_q, cmp_s2_q, ocp_s1_q, ocp_s2_q;
    logic [3:0] misc_s1_q, misc_s2_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_s1_q <= 2'h0;
            cmp_s2_q <= 2'h0;
            ocp_s1_q <= 2'h0;
            ocp_s2_q <= 2'h0;
            misc_s1_q <= 4'h0;
            misc_s2_q <= 4'h0;
        end
        else
        begin
            cmp_s1_q <= sense_above_ref;
            cmp_s2_q <= cmp_s1_q;
            ocp_s1_q <= overcurrent;
            ocp_s2_q <= ocp_s1_q;
            misc_s1_q <= {shutdown_temperature, temp_safe, fault_line_in, fault_below_release};
            misc_s2_q <= misc_s1_q;
        end
    end
    logic therm_hot, therm_safe, fault_rel;
    assign therm_hot = misc_s2_q[3];
    assign therm_safe = misc_s2_q[2];
    assign fault_rel = misc_s2_q[0];

    // registers
    logic [3:0] ctrl_q;
    logic [bcc_pkg::CNT_W-1:0] off_time_pin_q;
    logic [bcc_pkg::REF_SIGN:0] ref_a_q, ref_b_q;
    logic [bcc_pkg::ST_W-1:0] stat_q, mask_q;
    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == bcc_pkg::ADDR_CTRL) || (a == bcc_pkg::ADDR_OFF_TIME_PIN)
            || (a == bcc_pkg::ADDR_REF_A) || (a == bcc_pkg::ADDR_REF_B)
            || (a == bcc_pkg::ADDR_STAT) || (a == bcc_pkg::ADDR_MASK)
            || (a == bcc_pkg::ADDR_STATE);
    endfunction
    assign pslverr = psel && penable && !addr_ok(paddr);

    // off time clamp to supported span
    function automatic logic [bcc_pkg::CNT_W-1:0] clamp_off_time_pin(input logic [31:0] v);
        if (v < 32'(bcc_pkg::OFF_TIME_PIN_MIN_CYC))
            clamp_off_time_pin = bcc_pkg::CNT_W'(bcc_pkg::OFF_TIME_PIN_MIN_CYC);
        else if (v > 32'(bcc_pkg::OFF_TIME_PIN_MAX_CYC))
            clamp_off_time_pin = bcc_pkg::CNT_W'(bcc_pkg::OFF_TIME_PIN_MAX_CYC);
        else
            clamp_off_time_pin = v[bcc_pkg::CNT_W-1:0];
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 4'h0;
            off_time_pin_q <= bcc_pkg::OFF_TIME_PIN_RST;
            ref_a_q <= 9'h000;
            ref_b_q <= 9'h000;
            mask_q <= 4'h0;
        end
        else if (wr)
        begin
            unique case (paddr)
                bcc_pkg::ADDR_CTRL: ctrl_q <= pwdata[3:0];
                bcc_pkg::ADDR_OFF_TIME_PIN: off_time_pin_q <= clamp_off_time_pin(pwdata);
                bcc_pkg::ADDR_REF_A: ref_a_q <= pwdata[bcc_pkg::REF_SIGN:0];
                bcc_pkg::ADDR_REF_B: ref_b_q <= pwdata[bcc_pkg::REF_SIGN:0];
                bcc_pkg::ADDR_MASK: mask_q <= pwdata[bcc_pkg::ST_W-1:0];
                default: ;
            endcase
        end
    end

    // protection
    logic ocp_latch_q, therm_latch_q;
    logic ocp_any, stage_off;
    assign ocp_any = |ocp_s2_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ocp_latch_q <= 1'b0;
        else if (ocp_any)
            ocp_latch_q <= 1'b1;
        else if (ocp_latch_q && fault_rel)
            ocp_latch_q <= 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            therm_latch_q <= 1'b0;
        else if (therm_hot)
            therm_latch_q <= 1'b1;
        else if (therm_latch_q && therm_safe)
            therm_latch_q <= 1'b0;
    end
    assign stage_off = ocp_latch_q || therm_latch_q;
    assign fault_line_out = 1'b0;
    assign fault_line_oe = stage_off;

    // per bridge chopper
    bcc_pkg::bcc_phase_e phase_q [2];
    logic [bcc_pkg::CNT_W-1:0] cnt_q [2];
    logic [1:0] trip_ev;
    logic [bcc_pkg::CNT_W+2:0] slow_len;
    assign slow_len = (bcc_pkg::CNT_W+3)'((off_time_pin_q * bcc_pkg::SLOW_NUM) >> bcc_pkg::SLOW_SHIFT);

    for (genvar b = 0; b < 2; b++)
    begin : g_br
        logic [bcc_pkg::REF_SIGN:0] rf;
        logic en, zero, rev;
        assign rf = (b == 0) ? ref_a_q : ref_b_q;
        assign en = ctrl_q[b];
        assign zero = !en || (rf[bcc_pkg::REF_W-1:0] == 8'h00);
        assign rev = rf[bcc_pkg::REF_SIGN];
        assign trip_ev[b] = (phase_q[b] == bcc_pkg::PH_ON) && cmp_s2_q[b] && !zero;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                phase_q[b] <= bcc_pkg::PH_ON;
                cnt_q[b] <= '0;
            end
            else
            begin
                unique case (phase_q[b])
                    bcc_pkg::PH_ON:
                    begin
                        if (trip_ev[b])
                        begin
                            phase_q[b] <= bcc_pkg::PH_SLOW;
                            cnt_q[b] <= off_time_pin_q - 13'h0001;
                        end
                    end
                    bcc_pkg::PH_SLOW:
                    begin
                        cnt_q[b] <= cnt_q[b] - 13'h0001;
                        if ({3'h0, off_time_pin_q - cnt_q[b]} >= slow_len)
                            phase_q[b] <= bcc_pkg::PH_FAST;
                    end
                    bcc_pkg::PH_FAST:
                    begin
                        if (cnt_q[b] == '0)
                            phase_q[b] <= bcc_pkg::PH_ON;
                        else
                            cnt_q[b] <= cnt_q[b] - 13'h0001;
                    end
                    default: phase_q[b] <= bcc_pkg::PH_ON;
                endcase
            end
        end

        logic hs1, ls1, hs2, ls2;
        always_comb
        begin
            hs1 = 1'b0;
            ls1 = 1'b0;
            hs2 = 1'b0;
            ls2 = 1'b0;
            if (!zero && !stage_off)
            begin
                unique case (phase_q[b])
                    bcc_pkg::PH_ON:
                    begin
                        hs1 = !rev;
                        ls2 = !rev;
                        ls1 = rev;
                        hs2 = rev;
                    end
                    bcc_pkg::PH_SLOW:
                    begin
                        ls1 = 1'b1;
                        ls2 = 1'b1;
                    end
                    default:
                    begin
                        ls1 = !rev;
                        ls2 = rev;
                    end
                endcase
            end
        end
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                high_switch_term1[b] <= 1'b0;
                low_switch_term1[b] <= 1'b0;
                high_switch_term2[b] <= 1'b0;
                low_switch_term2[b] <= 1'b0;
            end
            else
            begin
                high_switch_term1[b] <= hs1;
                low_switch_term1[b] <= ls1;
                high_switch_term2[b] <= hs2;
                low_switch_term2[b] <= ls2;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            target_reference_a <= 8'h00;
            target_reference_b <= 8'h00;
        end
        else
        begin
            target_reference_a <= ref_a_q[bcc_pkg::REF_W-1:0];
            target_reference_b <= ref_b_q[bcc_pkg::REF_W-1:0];
        end
    end

    // sticky status, set wins over write-one-to-clear
    logic [bcc_pkg::ST_W-1:0] ev, clr;
    assign ev = {therm_latch_q, ocp_latch_q, trip_ev};
    assign clr = (wr && paddr == bcc_pkg::ADDR_STAT) ? pwdata[bcc_pkg::ST_W-1:0] : 4'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= 4'h0;
        else
            stat_q <= (stat_q & ~clr) | ev;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |((stat_q & ~clr | ev) & mask_q);
    end

    // read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= bcc_pkg::RDATA_ZERO;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                bcc_pkg::ADDR_CTRL: prdata <= {28'h0, ctrl_q};
                bcc_pkg::ADDR_OFF_TIME_PIN: prdata <= {19'h0, off_time_pin_q};
                bcc_pkg::ADDR_REF_A: prdata <= {23'h0, ref_a_q};
                bcc_pkg::ADDR_REF_B: prdata <= {23'h0, ref_b_q};
                bcc_pkg::ADDR_STAT: prdata <= {28'h0, stat_q};
                bcc_pkg::ADDR_MASK: prdata <= {28'h0, mask_q};
                bcc_pkg::ADDR_STATE: prdata <= {24'h0, 2'h0, stage_off, fault_line_oe,
                    phase_q[1], phase_q[0]};
                default: prdata <= bcc_pkg::RDATA_ZERO;
            endcase
        end
    end
endmodule // bcc_chopper

//--- testbench/bcc_monitor.sv
// port checker for the chopper
`timescale 1ns/10ps
module bcc_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic [7:0] paddr, // address
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [1:0] overcurrent, // ocp
    input wire logic shutdown_temperature, // hot
    input wire logic temp_safe, // cooled
    input wire logic fault_below_release, // pin low
    input wire logic fault_line_out, // pin value
    input wire logic fault_line_oe, // pull-down
    input wire logic [1:0] high_switch_term1, // leg
    input wire logic [1:0] low_switch_term1, // leg
    input wire logic [1:0] high_switch_term2, // leg
    input wire logic [1:0] low_switch_term2 // leg
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic [1:0] sw_on = high_switch_term1 | low_switch_term1
        | high_switch_term2 | low_switch_term2;
    no_shoot_a: assert property (!(|(high_switch_term1 & low_switch_term1))
        && !(|(high_switch_term2 & low_switch_term2))) else $error("leg shoot-through");
    drain_only_a: assert property (fault_line_out == 1'b0)
        else $error("fault pin driven high");
    ocp_trip_a: assert property ((overcurrent != 2'b00) [*3] |-> ##[0:3] fault_line_oe)
        else $error("ocp without pull-down");
    hot_trip_a: assert property (shutdown_temperature [*3] |-> ##[0:3] fault_line_oe)
        else $error("hot without pull-down");
    stage_off_a: assert property (fault_line_oe |=> sw_on == 2'b00)
        else $error("switch on during fault");
    fault_hold_a: assert property ((fault_line_oe && !fault_below_release
        && !temp_safe) [*4] |=> fault_line_oe) else $error("fault released early");
    decay_start_a: assert property (!fault_line_oe && $fell(high_switch_term1[0])
        |-> low_switch_term1[0] && low_switch_term2[0]) else $error("decay not slow");
    apb_err_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr && pready)
        else $error("unmapped not refused");
endmodule // bcc_monitor

bind bcc_chopper bcc_monitor mon_u (.*);

//--- testbench/bcc_motor.sv
// winding current model feeding the sense comparators
`timescale 1ns/10ps
module bcc_motor (
    input wire logic pclk, // clock
    input wire logic [1:0] high_switch_term1, // leg
    input wire logic [1:0] low_switch_term1, // leg
    input wire logic [1:0] high_switch_term2, // leg
    input wire logic [1:0] low_switch_term2, // leg
    input wire logic [7:0] target_reference_a, // level a
    input wire logic [7:0] target_reference_b, // level b
    output logic [1:0] sense_above_ref = 2'b00 // comparators
);
    int cur [2];
    always @(posedge pclk)
    begin
        for (int b = 0; b < 2; b++)
        begin
            if ((high_switch_term1[b] & low_switch_term2[b])
                | (low_switch_term1[b] & high_switch_term2[b]))
                cur[b] <= cur[b] + 1;
            else if (cur[b] > 0)
                cur[b] <= cur[b] - 1;
        end
        sense_above_ref <= {cur[1] > target_reference_b, cur[0] > target_reference_a};
    end
endmodule // bcc_motor

//--- testbench/tb_bridge_current_chopper_protection.sv
// self-checking bench for the chopper
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_bridge_current_chopper_protection;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, fault_line_out, fault_line_oe, irq;
    logic [1:0] sense_above_ref;
    logic [1:0] overcurrent = 0;
    logic shutdown_temperature = 0;
    logic temp_safe = 1;
    logic fault_below_release = 0;
    logic [7:0] target_reference_a, target_reference_b;
    logic [1:0] high_switch_term1, low_switch_term1, high_switch_term2, low_switch_term2;
    logic [3:0] acc;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 44714;
    int s, f, t;
    wire logic fault_line_in = fault_line_oe ? fault_line_out : 1'b1;
    always #12.5 pclk = ~pclk;
    bcc_chopper dut_u (.*);
    bcc_motor motor_u (.*);
    function automatic logic [3:0] pat(input int b);
        return {high_switch_term1[b], low_switch_term1[b], high_switch_term2[b],
            low_switch_term2[b]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wait_pat(input int b, input logic [3:0] p);
        int n = 0;
        while (pat(b) !== p && n < 20000)
        begin
            n++;
            @(posedge pclk);
        end
        `CHK("phase", p, pat(b))
    endtask
    task automatic chop(input int b, input logic [3:0] onp, input logic [3:0] fp);
        wait_pat(b, onp);
        wait_pat(b, 4'b0101);
        s = 0;
        f = 0;
        while (pat(b) === 4'b0101)
        begin
            s++;
            @(posedge pclk);
        end
        while (pat(b) === fp)
        begin
            f++;
            @(posedge pclk);
        end
        `CHK("slow", (5 * t) / 8, s)
        `CHK("off", t, s + f)
        `CHK("resume", onp, pat(b))
        $display("chop bridge %0d done", b);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            test_done;
        end
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        `CHK("sw", 4'b0000, pat(0) | pat(1))
        apb(0, bcc_pkg::ADDR_OFF_TIME_PIN, 0);
        `CHK("offtime rst", {19'h0, bcc_pkg::OFF_TIME_PIN_RST}, rd)
        apb(0, 8'h40, 0);
        `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        apb(1, bcc_pkg::ADDR_REF_B, 32'h100 | (20 + ($random(seed) & 63)));
        apb(1, bcc_pkg::ADDR_CTRL, 3);
        acc = 0;
        repeat (100)
        begin
            acc |= pat(0);
            @(posedge pclk);
        end
        `CHK("zero", 4'b0000, acc)
        apb(1, bcc_pkg::ADDR_REF_A, 20 + ($random(seed) & 63));
        for (int i = 0; i < 2; i++)
        begin
            t = i ? 400 : 400 + ($random(seed) & 1023);
            apb(1, bcc_pkg::ADDR_OFF_TIME_PIN, t);
            apb(0, bcc_pkg::ADDR_OFF_TIME_PIN, 0);
            `CHK("offtime", t, rd)
            chop(0, 4'b1001, 4'b0100);
            chop(1, 4'b0110, 4'b0001);
        end
        for (int b = 0; b < 2; b++)
        begin
            overcurrent <= 2'b01 << b;
            repeat (6) @(posedge pclk);
            `CHK("ocp oe", 1'b1, fault_line_oe)
            `CHK("ocp sw", 4'b0000, pat(0) | pat(1))
            overcurrent <= 0;
            repeat (10) @(posedge pclk);
            `CHK("ocp hold", 1'b1, fault_line_oe)
            fault_below_release <= 1;
            repeat (6) @(posedge pclk);
            `CHK("ocp free", 1'b0, fault_line_oe)
            fault_below_release <= 0;
        end
        $display("overcurrent test done");
        apb(1, bcc_pkg::ADDR_MASK, 0);
        shutdown_temperature <= 1;
        temp_safe <= 0;
        repeat (6) @(posedge pclk);
        `CHK("hot oe", 1'b1, fault_line_oe)
        `CHK("irq masked", 1'b0, irq)
        apb(1, bcc_pkg::ADDR_MASK, 32'hf);
        repeat (2) @(posedge pclk);
        `CHK("irq on", 1'b1, irq)
        apb(1, bcc_pkg::ADDR_CTRL, 0);
        shutdown_temperature <= 0;
        repeat (10) @(posedge pclk);
        `CHK("hot hold", 1'b1, fault_line_oe)
        temp_safe <= 1;
        repeat (6) @(posedge pclk);
        `CHK("hot free", 1'b0, fault_line_oe)
        apb(1, bcc_pkg::ADDR_STAT, 32'hf);
        apb(0, bcc_pkg::ADDR_STAT, 0);
        `CHK("stat clr", 32'h0, rd)
        repeat (2) @(posedge pclk);
        `CHK("irq clr", 1'b0, irq)
        $display("thermal and interrupt test done");
        test_done;
    end
endmodule // tb_bridge_current_chopper_protection
